// file: hdl/dchio_defs.svh
// Constants of the disc controller host bus and drive I/O glue
// Operation
// R1: Slave during host setup; no arbitration then
// R2: Slave selected only by fixed base address
// R3: Bus master for direct memory transfers
// R4: Firmware drives bus sync, releases bus
// R5: Transceiver enable is address OR data enable
// R6: Transceiver enable sets host driver direction
// R7: Host data buffered into 16-bit word
// R8: Output bytes held, then driven to host
// R9: Serial read data deserialized into bytes
// R10: Buffer bytes serialized to drive data cable
// R11: Control cable outputs from two latches
// R12: Drive status sampled; read when selected
// R13: One shared control cable, per-drive data
// R14: Byte boundary tracked by bit counter
`ifndef DCHIO_DEFS_SVH
`define DCHIO_DEFS_SVH
// Slave base address, compared above the register block
`define DCHIO_BASE_ADDR 18'h3fdc0
`define DCHIO_SEL_LSB 4
// Bus control latch bit positions
`define DCHIO_BC_AEN 0
`define DCHIO_BC_DEN 1
`define DCHIO_BC_DMR 2
`define DCHIO_BC_RPLY 3
`define DCHIO_BC_SACK 4
`define DCHIO_BC_SYNC 5
`define DCHIO_BC_DIN 6
`define DCHIO_BC_DOUT 7
// System control latch bit positions
`define DCHIO_SC_RD 0
`define DCHIO_SC_WR 1
// Drive unit select bit inside the tag latch
`define DCHIO_TAG_UNIT 0
// Reset values
`define DCHIO_RST_BYTE 8'h00
`define DCHIO_RST_WORD 16'h0000
// Write bit cell time and its clock count
`define DCHIO_CLK_NS 100
`define DCHIO_WBIT_NS 400
`define DCHIO_WBIT_CYC ((`DCHIO_WBIT_NS + `DCHIO_CLK_NS - 1) / `DCHIO_CLK_NS)
`endif

// file: hdl/dchio_pkg.sv
// Types of the disc controller host bus and drive I/O glue
package dchio_pkg;
  // Output bus destinations
  typedef enum logic [3:0] {
    DEST_DOUT_HI = 4'h0, DEST_DOUT_LO = 4'h1, DEST_DMA_HI = 4'h2,
    DEST_DMA_LO = 4'h3, DEST_TAGS = 4'h4, DEST_CTLBUS = 4'h5,
    DEST_SYSCTL = 4'h6, DEST_BUSCTL = 4'h7
  } dchio_dest_t;
  // Input bus sources
  typedef enum logic [3:0] {
    SRC_SLV_LO = 4'h0, SRC_SLV_HI = 4'h1, SRC_DIN_HI = 4'h2,
    SRC_DIN_LO = 4'h3, SRC_BUS_STAT = 4'h4, SRC_RD_BUF = 4'h5,
    SRC_DISC_STAT = 4'h6, SRC_UNIT_STAT = 4'h7
  } dchio_src_t;
  // Shift register modes
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00, SH_READ = 2'b01, SH_WRITE = 2'b10
  } dchio_sh_t;
endpackage

// file: hdl/dchio_top.sv
// Host bus and drive I/O glue of the disc controller
`timescale 1ns/100ps
`include "dchio_defs.svh"
module dchio_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] MICRO_OUTPUT_BYTE_I,
  input wire logic MICRO_LOAD_I,
  input wire logic [3:0] MICRO_DEST_I,
  input wire logic [3:0] MICRO_SRC_I,
  output logic [7:0] MICRO_DATA_O,
  input wire logic [15:0] HOST_DAL_I,
  output logic [15:0] HOST_DAL_O,
  output logic HOST_DAL_OE_O,
  output logic BUS_TRANSCEIVER_ENABLE_O,
  input wire logic HOST_BS7_I,
  input wire logic HOST_SYNC_I,
  input wire logic HOST_DIN_I,
  input wire logic HOST_DOUT_I,
  input wire logic HOST_DMG_I,
  output logic HOST_SYNC_O,
  output logic HOST_DIN_O,
  output logic HOST_DOUT_O,
  output logic HOST_RPLY_O,
  output logic HOST_DMR_O,
  output logic HOST_SACK_O,
  output logic [7:0] DRV_TAGS_O,
  output logic [7:0] DRV_CTLBUS_O,
  input wire logic [7:0] DRV_STATUS_I,
  input wire logic [1:0] DRV_RDATA_I,
  input wire logic [1:0] DRV_RCLK_I,
  output logic [1:0] DRV_WDATA_O,
  output logic [1:0] DRV_WCLK_O,
  input wire logic [7:0] BUF_BYTE_I,
  input wire logic BUF_VALID_I,
  output logic BUF_TAKE_O,
  output logic [7:0] RD_BYTE_O,
  output logic RD_VALID_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int PB_BS7 = 16, PB_SYNC = 17, PB_DIN = 18, PB_DOUT = 19, PB_DMG = 20;
  localparam int PB_RDAT = 29, PB_RCLK = 31;
  localparam logic [2:0] WDIV_LAST = 3'(`DCHIO_WBIT_CYC - 1);
  localparam logic [2:0] WDIV_HALF = 3'(`DCHIO_WBIT_CYC / 2);
  logic [32:0] pin_raw, pin_s1, pin_s2;
  logic [1:0] rclk_d;
  logic sync_d;
  assign pin_raw = {DRV_RCLK_I, DRV_RDATA_I, DRV_STATUS_I, HOST_DMG_I, HOST_DOUT_I,
                    HOST_DIN_I, HOST_SYNC_I, HOST_BS7_I, HOST_DAL_I};

  // Two flops per pin, third stage only for edges
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1 <= 33'h0;
      pin_s2 <= 33'h0;
      rclk_d <= 2'h0;
      sync_d <= 1'b0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      rclk_d <= pin_s2[PB_RCLK +: 2];
      sync_d <= pin_s2[PB_SYNC];
    end
  end

  // Slave address match against the fixed base
  function automatic logic f_hit(input logic bs7, input logic [15:0] adr);
    logic [17:0] full;
    full = {bs7, bs7, adr};
    f_hit = bs7 && (full[17:`DCHIO_SEL_LSB] == 14'(`DCHIO_BASE_ADDR >> `DCHIO_SEL_LSB));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Output latches and host bus side
  logic [15:0] dout_word, next_dout_word, dma_addr, next_dma_addr, slv_addr, next_slv_addr;
  logic [15:0] host_word, next_host_word, next_dal_o;
  logic [7:0] sysctl, next_sysctl, busctl, next_busctl, disc_stat, next_disc_stat;
  logic [7:0] next_tags, next_ctlbus, next_micro_data, bus_stat, unit_stat;
  logic slv_sel, next_slv_sel, next_dal_oe, next_dmr, next_sack, load, unit, underrun, nxt_full;
  logic [2:0] bit_cnt;
  dchio_pkg::dchio_sh_t sh_state;
  assign load = MICRO_LOAD_I;
  assign unit = DRV_TAGS_O[`DCHIO_TAG_UNIT];
  assign bus_stat = {pin_s2[PB_DMG], pin_s2[PB_SYNC], pin_s2[PB_DIN], pin_s2[PB_DOUT],
                     slv_sel, underrun, nxt_full, RD_VALID_O};
  assign unit_stat = {sh_state, unit, bit_cnt, 2'h0};
  // Next values of latches, slave decode and host drivers
  always_comb begin
    next_dout_word = dout_word;
    next_dma_addr = dma_addr;
    next_tags = DRV_TAGS_O;
    next_ctlbus = DRV_CTLBUS_O;
    next_sysctl = sysctl;
    next_busctl = busctl;
    if (load) begin // [R8] [R11]
      case (dchio_pkg::dchio_dest_t'(MICRO_DEST_I))
        dchio_pkg::DEST_DOUT_HI: next_dout_word[15:8] = MICRO_OUTPUT_BYTE_I;
        dchio_pkg::DEST_DOUT_LO: next_dout_word[7:0] = MICRO_OUTPUT_BYTE_I;
        dchio_pkg::DEST_DMA_HI: next_dma_addr[15:8] = MICRO_OUTPUT_BYTE_I;
        dchio_pkg::DEST_DMA_LO: next_dma_addr[7:0] = MICRO_OUTPUT_BYTE_I;
        dchio_pkg::DEST_TAGS: next_tags = MICRO_OUTPUT_BYTE_I;
        dchio_pkg::DEST_CTLBUS: next_ctlbus = MICRO_OUTPUT_BYTE_I;
        dchio_pkg::DEST_SYSCTL: next_sysctl = MICRO_OUTPUT_BYTE_I;
        dchio_pkg::DEST_BUSCTL: next_busctl = MICRO_OUTPUT_BYTE_I;
        default: next_busctl = busctl;
      endcase
    end
    // Address phase from the host selects this slave
    next_slv_addr = slv_addr;
    next_slv_sel = slv_sel;
    if (!busctl[`DCHIO_BC_SYNC] && pin_s2[PB_SYNC] && !sync_d) begin
      next_slv_addr = pin_s2[15:0];
      next_slv_sel = f_hit(pin_s2[PB_BS7], pin_s2[15:0]); // [R2]
    end else if (!pin_s2[PB_SYNC]) begin
      next_slv_sel = 1'b0;
    end
    // Host data word buffered for the input mux
    next_host_word = host_word;
    if ((slv_sel && pin_s2[PB_DOUT]) || busctl[`DCHIO_BC_DIN]) begin
      next_host_word = pin_s2[15:0]; // [R7]
    end
    next_disc_stat = pin_s2[PB_DMG + 1 +: 8]; // [R12]
    // Input bus source mux
    case (dchio_pkg::dchio_src_t'(MICRO_SRC_I))
      dchio_pkg::SRC_SLV_LO: next_micro_data = slv_addr[7:0];
      dchio_pkg::SRC_SLV_HI: next_micro_data = slv_addr[15:8];
      dchio_pkg::SRC_DIN_HI: next_micro_data = host_word[15:8];
      dchio_pkg::SRC_DIN_LO: next_micro_data = host_word[7:0];
      dchio_pkg::SRC_BUS_STAT: next_micro_data = bus_stat;
      dchio_pkg::SRC_RD_BUF: next_micro_data = RD_BYTE_O;
      dchio_pkg::SRC_DISC_STAT: next_micro_data = disc_stat; // [R12]
      dchio_pkg::SRC_UNIT_STAT: next_micro_data = unit_stat;
      default: next_micro_data = `DCHIO_RST_BYTE;
    endcase
    // Drivers face the host only while an enable phase runs
    next_dal_oe = busctl[`DCHIO_BC_AEN] | busctl[`DCHIO_BC_DEN]; // [R5] [R6]
    next_dal_o = busctl[`DCHIO_BC_AEN] ? dma_addr : dout_word; // [R8]
    next_dmr = busctl[`DCHIO_BC_DMR] & ~slv_sel; // [R1] [R3] [R4]
    next_sack = busctl[`DCHIO_BC_SACK] & pin_s2[PB_DMG] & ~slv_sel; // [R1] [R3]
  end

  // Register the latch group
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dout_word <= `DCHIO_RST_WORD;
      dma_addr <= `DCHIO_RST_WORD;
      DRV_TAGS_O <= `DCHIO_RST_BYTE;
      DRV_CTLBUS_O <= `DCHIO_RST_BYTE;
      sysctl <= `DCHIO_RST_BYTE;
      busctl <= `DCHIO_RST_BYTE;
      slv_addr <= `DCHIO_RST_WORD;
      slv_sel <= 1'b0;
      host_word <= `DCHIO_RST_WORD;
      disc_stat <= `DCHIO_RST_BYTE;
      MICRO_DATA_O <= `DCHIO_RST_BYTE;
      HOST_DAL_O <= `DCHIO_RST_WORD;
      HOST_DAL_OE_O <= 1'b0;
      BUS_TRANSCEIVER_ENABLE_O <= 1'b0;
      HOST_SYNC_O <= 1'b0;
      HOST_DIN_O <= 1'b0;
      HOST_DOUT_O <= 1'b0;
      HOST_RPLY_O <= 1'b0;
      HOST_DMR_O <= 1'b0;
      HOST_SACK_O <= 1'b0;
    end else begin
      dout_word <= next_dout_word;
      dma_addr <= next_dma_addr;
      DRV_TAGS_O <= next_tags;
      DRV_CTLBUS_O <= next_ctlbus;
      sysctl <= next_sysctl;
      busctl <= next_busctl;
      slv_addr <= next_slv_addr;
      slv_sel <= next_slv_sel;
      host_word <= next_host_word;
      disc_stat <= next_disc_stat;
      MICRO_DATA_O <= next_micro_data;
      HOST_DAL_O <= next_dal_o;
      HOST_DAL_OE_O <= next_dal_oe;
      BUS_TRANSCEIVER_ENABLE_O <= next_dal_oe;
      HOST_SYNC_O <= busctl[`DCHIO_BC_SYNC];
      HOST_DIN_O <= busctl[`DCHIO_BC_DIN];
      HOST_DOUT_O <= busctl[`DCHIO_BC_DOUT];
      HOST_RPLY_O <= busctl[`DCHIO_BC_RPLY] & slv_sel;
      HOST_DMR_O <= next_dmr;
      HOST_SACK_O <= next_sack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read/write shift register
  dchio_pkg::dchio_sh_t next_sh_state;
  logic [7:0] sh, next_sh, nxt_byte, next_nxt_byte, next_rd_byte;
  logic [2:0] next_bit_cnt, wdiv, next_wdiv;
  logic next_nxt_full, next_underrun, next_rd_valid, next_take, wbit, next_wbit;
  logic r_edge, r_bit, w_tick;
  logic [1:0] next_wdata, next_wclk;
  assign r_edge = pin_s2[PB_RCLK + 32'(unit)] & ~rclk_d[unit];
  assign r_bit = pin_s2[PB_RDAT + 32'(unit)];
  assign w_tick = (wdiv == WDIV_LAST);
  // Mode, bit count, serial and parallel sides
  always_comb begin
    next_sh_state = sh_state;
    next_sh = sh;
    next_bit_cnt = bit_cnt;
    next_nxt_byte = nxt_byte;
    next_nxt_full = nxt_full;
    next_underrun = underrun;
    next_wdiv = 3'h0;
    next_rd_byte = RD_BYTE_O;
    next_rd_valid = 1'b0;
    next_take = 1'b0;
    next_wbit = wbit;
    case (sh_state)
      dchio_pkg::SH_IDLE: begin
        next_bit_cnt = 3'h0;
        next_wbit = 1'b0;
        if (sysctl[`DCHIO_SC_RD]) begin
          next_sh_state = dchio_pkg::SH_READ;
        end else if (sysctl[`DCHIO_SC_WR]) begin
          next_sh_state = dchio_pkg::SH_WRITE;
          next_underrun = 1'b0;
        end
      end
      dchio_pkg::SH_READ: begin
        if (!sysctl[`DCHIO_SC_RD]) begin
          next_sh_state = dchio_pkg::SH_IDLE;
        end else if (r_edge) begin // [R9]
          next_sh = {sh[6:0], r_bit};
          next_bit_cnt = bit_cnt + 3'h1; // [R14]
          if (bit_cnt == 3'h7) begin
            next_rd_byte = {sh[6:0], r_bit};
            next_rd_valid = 1'b1;
          end
        end
      end
      dchio_pkg::SH_WRITE: begin
        next_wdiv = w_tick ? 3'h0 : wdiv + 3'h1;
        if (!sysctl[`DCHIO_SC_WR]) begin
          next_sh_state = dchio_pkg::SH_IDLE;
        end
        if (w_tick && bit_cnt == 3'h0) begin // [R10] [R14]
          next_sh = {nxt_byte[6:0], 1'b0};
          next_wbit = nxt_byte[7];
          next_underrun = underrun | ~nxt_full;
          next_nxt_full = 1'b0;
          next_bit_cnt = 3'h1;
        end else if (w_tick) begin
          next_sh = {sh[6:0], 1'b0};
          next_wbit = sh[7];
          next_bit_cnt = bit_cnt + 3'h1;
        end
        if (!nxt_full && BUF_VALID_I) begin // [R10] Take after unload, so a take wins
          next_nxt_byte = BUF_BYTE_I;
          next_nxt_full = 1'b1;
          next_take = 1'b1;
        end
      end
      default: next_sh_state = dchio_pkg::SH_IDLE;
    endcase
    // Only the selected drive's data channel is driven
    next_wdata = 2'h0;
    next_wclk = 2'h0;
    if (next_sh_state == dchio_pkg::SH_WRITE) begin // [R13]
      next_wdata[unit] = next_wbit;
      next_wclk[unit] = (next_wdiv < WDIV_HALF);
    end
  end

  // Register the shift group
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sh_state <= dchio_pkg::SH_IDLE;
      sh <= `DCHIO_RST_BYTE;
      bit_cnt <= 3'h0;
      nxt_byte <= `DCHIO_RST_BYTE;
      nxt_full <= 1'b0;
      underrun <= 1'b0;
      wdiv <= 3'h0;
      wbit <= 1'b0;
      RD_BYTE_O <= `DCHIO_RST_BYTE;
      RD_VALID_O <= 1'b0;
      BUF_TAKE_O <= 1'b0;
      DRV_WDATA_O <= 2'h0;
      DRV_WCLK_O <= 2'h0;
    end else begin
      sh_state <= next_sh_state;
      sh <= next_sh;
      bit_cnt <= next_bit_cnt;
      nxt_byte <= next_nxt_byte;
      nxt_full <= next_nxt_full;
      underrun <= next_underrun;
      wdiv <= next_wdiv;
      wbit <= next_wbit;
      RD_BYTE_O <= next_rd_byte;
      RD_VALID_O <= next_rd_valid;
      BUF_TAKE_O <= next_take;
      DRV_WDATA_O <= next_wdata;
      DRV_WCLK_O <= next_wclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  txen_or_a: assert property (BUS_TRANSCEIVER_ENABLE_O == // [R5]
    $past(busctl[`DCHIO_BC_AEN] | busctl[`DCHIO_BC_DEN])) else $error("enable not OR");
  dal_dir_a: assert property (BUS_TRANSCEIVER_ENABLE_O |-> HOST_DAL_OE_O && // [R6]
    HOST_DAL_O == ($past(busctl[`DCHIO_BC_AEN]) ? $past(dma_addr) : $past(dout_word)))
    else $error("drivers not set by enable");
  dmr_slave_a: assert property ($past(slv_sel) |-> !HOST_DMR_O && !HOST_SACK_O) // [R1]
    else $error("arbitration during slave cycle");
  slv_dec_a: assert property ($rose(slv_sel) |-> f_hit($past(pin_s2[PB_BS7]), // [R2]
    slv_addr)) else $error("slave selected off base");
  dma_req_a: assert property ($past(busctl[`DCHIO_BC_DMR] && !slv_sel) |-> // [R3] [R4]
    HOST_DMR_O) else $error("bus request lost");
  word_cap_a: assert property (slv_sel && pin_s2[PB_DOUT] |=> // [R7]
    host_word == $past(pin_s2[15:0])) else $error("host word not buffered");
  dal_src_a: assert property (busctl[`DCHIO_BC_AEN] |=> HOST_DAL_O == $past(dma_addr)) // [R8]
    else $error("address not driven");
  tags_hold_a: assert property (load && MICRO_DEST_I == 4'h4 |=> // [R11]
    DRV_TAGS_O == $past(MICRO_OUTPUT_BYTE_I)) else $error("tag latch missed");
  stat_mux_a: assert property (MICRO_SRC_I == 4'h6 |=> MICRO_DATA_O == $past(disc_stat)) // [R12]
    else $error("disc status not routed");
  rd_byte_a: assert property (RD_VALID_O |-> bit_cnt == 3'h0 && // [R9] [R14]
    RD_BYTE_O == {$past(sh[6:0]), $past(r_bit)}) else $error("byte wrong");
  wr_bit_a: assert property (w_tick && sh_state == dchio_pkg::SH_WRITE && // [R10]
    bit_cnt == 3'h0 |=> wbit == $past(nxt_byte[7])) else $error("write bit wrong");
  one_drive_a: assert property ((DRV_WDATA_O & ~(2'h1 << unit)) == 2'h0 || // [R13]
    $changed(unit)) else $error("unselected drive written");
  read_byte_c: cover property (RD_VALID_O);
  write_take_c: cover property (BUF_TAKE_O ##[1:40] BUF_TAKE_O);
  slave_sel_c: cover property ($rose(slv_sel));
  dma_req_c: cover property ($rose(HOST_DMR_O));

endmodule // dchio_top

// file: test/dchio_drive_model.sv
// Behavioural disc drive on one serial data cable
`timescale 1ns/100ps
module dchio_drive_model (
  input wire logic wclk_i,
  input wire logic wdata_i,
  output logic rclk_o,
  output logic rdata_o
);
  logic [7:0] wr_byte;
  int wr_bits;
  ////////////////////////////////////////////////////////////////
  // Idle: read clock stands low, no stale data left on the line
  initial begin
    rclk_o = 1'b0;
    rdata_o = 1'b0;
    wr_bits = 0;
    wr_byte = 8'h00;
  end
  // Send one byte MSB first, data steady around each clock rise
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rdata_o = b[i];
      #400 rclk_o = 1'b1;
      #400 rclk_o = 1'b0;
    end
    rdata_o = ~rdata_o;
  endtask
  ////////////////////////////////////////////////////////////////
  // Collect write bits in mid cell, MSB first
  always @(negedge wclk_i) begin
    wr_byte = {wr_byte[6:0], wdata_i};
    wr_bits = wr_bits + 1;
  end
endmodule // dchio_drive_model

// file: test/tb.sv
// Self-checking bench of the host bus and drive I/O glue
`timescale 1ns/100ps
module tb;
  typedef struct {
    logic [3:0] dest;
    logic [7:0] val;
    logic [1:0] sel;
    logic [7:0] exp;
  } dchio_row_t;
  logic CLK_I, RST_I, MICRO_LOAD_I, HOST_DAL_OE_O, BUS_TRANSCEIVER_ENABLE_O;
  logic HOST_BS7_I, HOST_SYNC_I, HOST_DIN_I, HOST_DOUT_I, HOST_DMG_I;
  logic HOST_SYNC_O, HOST_DIN_O, HOST_DOUT_O, HOST_RPLY_O, HOST_DMR_O, HOST_SACK_O;
  logic BUF_VALID_I, BUF_TAKE_O, RD_VALID_O, wclk1_seen;
  logic [7:0] MICRO_OUTPUT_BYTE_I, MICRO_DATA_O, DRV_TAGS_O, DRV_CTLBUS_O, DRV_STATUS_I;
  logic [7:0] BUF_BYTE_I, RD_BYTE_O;
  logic [3:0] MICRO_DEST_I, MICRO_SRC_I;
  logic [15:0] HOST_DAL_I, HOST_DAL_O;
  logic [1:0] DRV_WDATA_O, DRV_WCLK_O;
  wire [1:0] DRV_RDATA_I, DRV_RCLK_I;
  int miscompares, tests_run, k;
  dchio_row_t rows [0:8];
  dchio_top uut (.CLK_I(CLK_I), .RST_I(RST_I), .MICRO_OUTPUT_BYTE_I(MICRO_OUTPUT_BYTE_I),
    .MICRO_LOAD_I(MICRO_LOAD_I), .MICRO_DEST_I(MICRO_DEST_I), .MICRO_SRC_I(MICRO_SRC_I),
    .MICRO_DATA_O(MICRO_DATA_O), .HOST_DAL_I(HOST_DAL_I), .HOST_DAL_O(HOST_DAL_O),
    .HOST_DAL_OE_O(HOST_DAL_OE_O), .BUS_TRANSCEIVER_ENABLE_O(BUS_TRANSCEIVER_ENABLE_O),
    .HOST_BS7_I(HOST_BS7_I), .HOST_SYNC_I(HOST_SYNC_I), .HOST_DIN_I(HOST_DIN_I),
    .HOST_DOUT_I(HOST_DOUT_I), .HOST_DMG_I(HOST_DMG_I), .HOST_SYNC_O(HOST_SYNC_O),
    .HOST_DIN_O(HOST_DIN_O), .HOST_DOUT_O(HOST_DOUT_O), .HOST_RPLY_O(HOST_RPLY_O),
    .HOST_DMR_O(HOST_DMR_O), .HOST_SACK_O(HOST_SACK_O), .DRV_TAGS_O(DRV_TAGS_O),
    .DRV_CTLBUS_O(DRV_CTLBUS_O), .DRV_STATUS_I(DRV_STATUS_I), .DRV_RDATA_I(DRV_RDATA_I),
    .DRV_RCLK_I(DRV_RCLK_I), .DRV_WDATA_O(DRV_WDATA_O), .DRV_WCLK_O(DRV_WCLK_O),
    .BUF_BYTE_I(BUF_BYTE_I), .BUF_VALID_I(BUF_VALID_I), .BUF_TAKE_O(BUF_TAKE_O),
    .RD_BYTE_O(RD_BYTE_O), .RD_VALID_O(RD_VALID_O));
  dchio_drive_model drv0 (.wclk_i(DRV_WCLK_O[0]), .wdata_i(DRV_WDATA_O[0]),
    .rclk_o(DRV_RCLK_I[0]), .rdata_o(DRV_RDATA_I[0]));
  dchio_drive_model drv1 (.wclk_i(DRV_WCLK_O[1]), .wdata_i(DRV_WDATA_O[1]),
    .rclk_o(DRV_RCLK_I[1]), .rdata_o(DRV_RDATA_I[1]));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    CLK_I = 1'b0;
    forever #50 CLK_I = ~CLK_I;
  end
  initial begin
    #8000000;
    miscompares++;
    close_out();
  end
  // Second drive's write clock must stay low while drive zero is written
  always @(posedge CLK_I) begin
    if (DRV_WCLK_O[1] === 1'b1) wclk1_seen = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic load(input logic [3:0] d, input logic [7:0] v);
    @(negedge CLK_I);
    MICRO_DEST_I = d;
    MICRO_OUTPUT_BYTE_I = v;
    MICRO_LOAD_I = 1'b1;
    @(negedge CLK_I);
    MICRO_LOAD_I = 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_I);
  endtask
  task automatic read_src(input logic [3:0] s, input logic [7:0] exp, input string name);
    MICRO_SRC_I = s;
    cyc(4);
    check(name, {8'h00, exp}, {8'h00, MICRO_DATA_O});
  endtask
  function automatic logic [7:0] obs(input logic [1:0] s);
    case (s)
      2'd0: obs = DRV_TAGS_O;
      2'd1: obs = DRV_CTLBUS_O;
      default: obs = {HOST_DOUT_O, HOST_DIN_O, HOST_SYNC_O, HOST_SACK_O, HOST_DMR_O,
        1'b0, BUS_TRANSCEIVER_ENABLE_O, HOST_DAL_OE_O};
    endcase
  endfunction
  task automatic close_out();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {MICRO_LOAD_I, HOST_BS7_I, HOST_SYNC_I, HOST_DIN_I, HOST_DOUT_I, BUF_VALID_I} = 6'h00;
    {MICRO_OUTPUT_BYTE_I, DRV_STATUS_I, BUF_BYTE_I} = 24'h000000;
    {MICRO_DEST_I, MICRO_SRC_I, HOST_DAL_I} = 24'h000000;
    HOST_DMG_I = 1'b1;
    miscompares = 0;
    tests_run = 0;
    wclk1_seen = 1'b0;
    rows[0] = '{4'h4, 8'h5a, 2'd0, 8'h5a};
    rows[1] = '{4'h5, 8'hc3, 2'd1, 8'hc3};
    rows[2] = '{4'h7, 8'h01, 2'd2, 8'h03};
    rows[3] = '{4'h7, 8'h02, 2'd2, 8'h03};
    rows[4] = '{4'h7, 8'h00, 2'd2, 8'h00};
    rows[5] = '{4'h7, 8'he0, 2'd2, 8'he0};
    rows[6] = '{4'h7, 8'h04, 2'd2, 8'h08};
    rows[7] = '{4'h7, 8'h10, 2'd2, 8'h10};
    rows[8] = '{4'h9, 8'hff, 2'd1, 8'hc3};
    RST_I = 1'b1;
    cyc(16);
    RST_I = 1'b0;
    check("reset outs", 16'h0000, {DRV_TAGS_O, DRV_CTLBUS_O});
    check("reset oe", 16'h0000, {HOST_DAL_OE_O, BUS_TRANSCEIVER_ENABLE_O, RD_VALID_O});
    // Latch table: control cable, transceiver enable, host control copies
    for (k = 0; k < 9; k++) begin
      load(rows[k].dest, rows[k].val);
      cyc(2);
      check("latch row", {8'h00, rows[k].exp}, {8'h00, obs(rows[k].sel)});
    end
    // Select acknowledge needs the grant input as well
    HOST_DMG_I = 1'b0;
    cyc(4);
    check("sack no grant", 16'h0000, {15'h0000, HOST_SACK_O});
    HOST_DMG_I = 1'b1;
    // Address then data words onto the host bus
    load(4'h2, 8'h12);
    load(4'h3, 8'h34);
    load(4'h0, 8'hab);
    load(4'h1, 8'hcd);
    load(4'h7, 8'h01);
    cyc(2);
    check("dma addr", 16'h1234, HOST_DAL_O);
    load(4'h7, 8'h02);
    cyc(2);
    check("data out", 16'habcd, HOST_DAL_O);
    // Slave cycle: foreign address, then own base address
    load(4'h7, 8'h0c);
    cyc(2);
    check("master req", 16'h0001, {HOST_RPLY_O, HOST_DMR_O});
    HOST_BS7_I = 1'b1;
    HOST_DAL_I = 16'hfdd0;
    HOST_SYNC_I = 1'b1;
    cyc(8);
    check("foreign", 16'h0001, {HOST_RPLY_O, HOST_DMR_O});
    HOST_SYNC_I = 1'b0;
    HOST_DAL_I = 16'h022f;
    cyc(4);
    HOST_DAL_I = 16'hfdc0;
    HOST_SYNC_I = 1'b1;
    cyc(8);
    check("selected", 16'h0004, {HOST_RPLY_O, HOST_DMR_O, HOST_SACK_O});
    read_src(4'h0, 8'hc0, "slave addr");
    HOST_DAL_I = 16'hbeef;
    HOST_DOUT_I = 1'b1;
    cyc(4);
    read_src(4'h3, 8'hef, "word lo");
    read_src(4'h2, 8'hbe, "word hi");
    {HOST_SYNC_I, HOST_DOUT_I, HOST_BS7_I} = 3'b000;
    HOST_DAL_I = 16'h4110;
    load(4'h7, 8'h00);
    // Drive status follows the pins continuously
    DRV_STATUS_I = 8'h96;
    read_src(4'h6, 8'h96, "status");
    DRV_STATUS_I = 8'h69;
    read_src(4'h6, 8'h69, "status");
    read_src(4'hf, 8'h00, "no source");
    // Serial read from the second drive
    load(4'h4, 8'h01);
    load(4'h6, 8'h01);
    fork
      drv1.send(8'h3c);
    join_none
    k = 0;
    while (RD_VALID_O !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    check("read wait", 16'h0000, {15'h0000, RD_VALID_O !== 1'b1});
    check("read byte", 16'h003c, {8'h00, RD_BYTE_O});
    read_src(4'h5, 8'h3c, "read src");
    read_src(4'h7, 8'h60, "unit stat");
    // Serial write to the first drive
    load(4'h4, 8'h00);
    wclk1_seen = 1'b0;
    BUF_BYTE_I = 8'ha5;
    BUF_VALID_I = 1'b1;
    load(4'h6, 8'h02);
    k = drv0.wr_bits + 9; // First cell after write entry carries no byte
    for (int i = 0; i < 400 && drv0.wr_bits < k; i++) begin
      if (BUF_TAKE_O === 1'b1) BUF_VALID_I = 1'b0;
      cyc(1);
    end
    check("write wait", 16'h0000, {15'h0000, drv0.wr_bits < k});
    check("write byte", 16'h00a5, {8'h00, drv0.wr_byte});
    check("other wclk", 16'h0000, {15'h0000, wclk1_seen});
    // No second byte offered: underrun sticks in bus status
    cyc(8);
    read_src(4'h4, 8'h84, "bus stat");
    close_out();
  end
endmodule // tb
